// file: hdl/crypto_dma_pkg.sv
// constants shared by the crypto engine DMA control block
// assumes a 25 MHz system clock and a 32-bit register port
package crypto_dma_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses on the register port)
   // ------------------------------------------------------------
   localparam logic [3:0]  CTRL_ADDR      = 4'h0;
   localparam logic [3:0]  STAT_ADDR      = 4'h4;
   localparam logic [3:0]  DESC_BASE_ADDR = 4'h8;

   // ------------------------------------------------------------
   // crypto_dma_control fields
   // ------------------------------------------------------------
   localparam int          OUT_SWAP_BIT   = 7;
   localparam int          SRST_BIT       = 6;
   localparam int          IN_SWAP_BIT    = 5;
   localparam int          FETCH_BIT      = 2;
   localparam int          POLL_BIT       = 1;
   localparam int          DMA_EN_BIT     = 0;
   localparam logic [7:0]  CTRL_WR_MASK   = 8'hA7;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;

   // ------------------------------------------------------------
   // crypto_dma_status fields
   // ------------------------------------------------------------
   localparam int          ACTIVE_BIT     = 16;

   // ------------------------------------------------------------
   // descriptor layout: word 0 header, 1 source, 2 destination, 3 next
   // ------------------------------------------------------------
   localparam int          DESC_VALID_BIT = 31;
   localparam int          DESC_LAST_BIT  = 15;
   localparam logic [31:0] WORD_STEP      = 32'h0000_0004;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          SOFT_RESET_NS  = 160;
   localparam int          POLL_GAP_NS    = 400;
   localparam int          SOFT_RESET_CYC = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          POLL_GAP_CYC   = POLL_GAP_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // descriptor processor states
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_DESC  = 5'h02,
      ST_POLL  = 5'h04,
      ST_READ  = 5'h08,
      ST_WRITE = 5'h10
   } proc_state_e;

endpackage

// file: hdl/byte_swap.sv
// reverses the byte order of a word when enabled
// assumes a width that is a whole number of bytes
`timescale 1ns/1ps
module byte_swap #(
   parameter int WIDTH = 32
) (
   // control
   input  wire logic             swap_en,
   // data
   input  wire logic [WIDTH-1:0] word_in,
   output logic      [WIDTH-1:0] word_out
);

   initial begin
      if (WIDTH % 8 != 0 || WIDTH < 8) begin
         $error("byte_swap width must be whole bytes");
      end
   end

   logic [WIDTH-1:0] swapped;

   always_comb begin
      swapped = '0;
      for (int i = 0; i < WIDTH / 8; i++) begin
         swapped[i*8 +: 8] = word_in[WIDTH-8-i*8 +: 8];
      end
   end

   assign word_out = swap_en ? swapped : word_in;

endmodule

// file: hdl/soft_reset_seq.sv
// stretches a soft reset request into a fixed-length busy window
// assumes start is a one-cycle pulse from same-clock logic
`timescale 1ns/1ps
module soft_reset_seq #(
   parameter int CYCLES = crypto_dma_pkg::SOFT_RESET_CYC
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic start,
   output logic      busy_reg
);

   initial begin
      if (CYCLES < 1 || CYCLES > 255) begin
         $error("soft_reset_seq cycles out of range");
      end
   end

   logic [7:0] count_reg;
   wire        last = (count_reg == 8'h01);

   // a fresh request while busy restarts the window
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_reg  <= 1'b0;
         count_reg <= 8'h00;
      end else if (start) begin
         busy_reg  <= 1'b1;
         count_reg <= 8'(CYCLES);
      end else if (busy_reg) begin
         busy_reg  <= !last;
         count_reg <= count_reg - 8'h01;
      end
   end

endmodule

// file: hdl/crypto_dma_ctrl.sv
// control, status and descriptor processor of the crypto engine DMA
// assumes a same-clock memory bus that answers a held request with a one-cycle ack
`timescale 1ns/1ps

// Operation
// - output swap set: every word the DMA writes is the input swap's result with its bytes reversed, so both swaps set cancel
// - writing one to soft reset starts engine reset; hardware clears it
// - input swap set: every data word the DMA reads has its bytes reversed; descriptor words are used as read
// - descriptors are fetched only while the fetch enable is one
// - with polling on, re-read a descriptor until valid; otherwise never poll
// - DMA transfers run only while the engine transfer enable is one
// - status active flag is one while the processor works, zero when idle
// - status low sixteen bits show the current descriptor control word
// - unimplemented control bits read zero; implemented bits reset to zero
module crypto_dma_ctrl #(
   parameter int POLL_CYCLES  = crypto_dma_pkg::POLL_GAP_CYC,
   parameter int RESET_CYCLES = crypto_dma_pkg::SOFT_RESET_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // system memory master
   output logic             mem_req,
   output logic             mem_we,
   output logic      [31:0] mem_addr,
   output logic      [31:0] mem_wdata,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_ack
);

   initial begin
      if (POLL_CYCLES < 1 || POLL_CYCLES > 255) begin
         $error("crypto_dma_ctrl poll gap out of range");
      end
   end

   function automatic logic [31:0] step(input logic [31:0] a);
      step = a + crypto_dma_pkg::WORD_STEP;
   endfunction

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]                  ctrl_reg;
   logic [31:0]                 desc_base_reg;
   logic [31:0]                 rdata_reg;
   crypto_dma_pkg::proc_state_e state_reg;
   logic [31:0]                 desc_ptr_reg;
   logic [1:0]                  word_idx_reg;
   logic [31:0]                 src_reg;
   logic [31:0]                 dst_reg;
   logic [31:0]                 next_reg;
   logic [15:0]                 cur_ctrl_reg;
   logic [7:0]                  count_reg;
   logic [7:0]                  poll_cnt_reg;
   logic                        done_reg;
   logic                        mem_req_reg;
   logic                        mem_we_reg;
   logic [31:0]                 mem_addr_reg;
   logic [31:0]                 mem_wdata_reg;
   logic                        soft_busy;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire        wr_ctrl   = reg_wr && (reg_addr == crypto_dma_pkg::CTRL_ADDR);
   wire        wr_base   = reg_wr && (reg_addr == crypto_dma_pkg::DESC_BASE_ADDR);
   wire        srst_req  = wr_ctrl && reg_wdata[crypto_dma_pkg::SRST_BIT];
   wire        dma_en    = ctrl_reg[crypto_dma_pkg::DMA_EN_BIT];
   wire        fetch_en  = ctrl_reg[crypto_dma_pkg::FETCH_BIT];
   wire        poll_en   = ctrl_reg[crypto_dma_pkg::POLL_BIT];
   wire        abort     = !dma_en || !fetch_en || soft_busy;
   wire        go        = !abort && !done_reg;
   wire        active    = (state_reg != crypto_dma_pkg::ST_IDLE);
   wire        desc_ok   = mem_rdata[crypto_dma_pkg::DESC_VALID_BIT];
   wire        last_desc = cur_ctrl_reg[crypto_dma_pkg::DESC_LAST_BIT];
   wire [31:0] ctrl_view = {24'h000000, ctrl_reg | {1'b0, soft_busy, 6'h00}};
   wire [31:0] stat_view = {15'h0000, active, cur_ctrl_reg};
   wire [31:0] in_word;
   wire [31:0] out_word;
   wire [31:0] rd_mux    = (reg_addr == crypto_dma_pkg::CTRL_ADDR)      ? ctrl_view :
                           (reg_addr == crypto_dma_pkg::STAT_ADDR)      ? stat_view :
                           (reg_addr == crypto_dma_pkg::DESC_BASE_ADDR) ? desc_base_reg :
                           32'h0000_0000;

   // ------------------------------------------------------------
   // data path: swap in, then swap out (the output swap takes the input swap's result directly)
   // ------------------------------------------------------------
   byte_swap #(.WIDTH(32)) u_in_swap (
      .swap_en  (ctrl_reg[crypto_dma_pkg::IN_SWAP_BIT]),
      .word_in  (mem_rdata),
      .word_out (in_word)
   );
   byte_swap #(.WIDTH(32)) u_out_swap (
      .swap_en  (ctrl_reg[crypto_dma_pkg::OUT_SWAP_BIT]),
      .word_in  (in_word),
      .word_out (out_word)
   );

   soft_reset_seq #(.CYCLES(RESET_CYCLES)) u_soft_reset (
      .clk      (clk),
      .rst      (rst),
      .start    (srst_req),
      .busy_reg (soft_busy)
   );

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   // soft reset bit lives in the sequencer, so it is masked out here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg      <= crypto_dma_pkg::CTRL_RESET;
         desc_base_reg <= 32'h0000_0000;
         rdata_reg     <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata[7:0] & crypto_dma_pkg::CTRL_WR_MASK;
         end
         if (wr_base) begin
            desc_base_reg <= reg_wdata;
         end
         rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // descriptor processor
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg     <= crypto_dma_pkg::ST_IDLE;
         desc_ptr_reg  <= 32'h0000_0000;
         word_idx_reg  <= 2'h0;
         src_reg       <= 32'h0000_0000;
         dst_reg       <= 32'h0000_0000;
         next_reg      <= 32'h0000_0000;
         cur_ctrl_reg  <= 16'h0000;
         count_reg     <= 8'h00;
         poll_cnt_reg  <= 8'h00;
         done_reg      <= 1'b0;
         mem_req_reg   <= 1'b0;
         mem_we_reg    <= 1'b0;
         mem_addr_reg  <= 32'h0000_0000;
         mem_wdata_reg <= 32'h0000_0000;
      end else if (abort) begin
         // halting drops the bus request at once; the memory must accept withdrawal
         state_reg   <= crypto_dma_pkg::ST_IDLE;
         mem_req_reg <= 1'b0;
         mem_we_reg  <= 1'b0;
         done_reg    <= 1'b0;
         if (soft_busy) begin
            cur_ctrl_reg <= 16'h0000;
         end
      end else begin
         case (state_reg)
            crypto_dma_pkg::ST_IDLE: begin
               if (go) begin
                  state_reg    <= crypto_dma_pkg::ST_DESC;
                  desc_ptr_reg <= desc_base_reg;
                  word_idx_reg <= 2'h0;
                  mem_req_reg  <= 1'b1;
                  mem_addr_reg <= desc_base_reg;
               end
            end
            crypto_dma_pkg::ST_DESC: begin
               if (mem_ack) begin
                  word_idx_reg <= word_idx_reg + 2'h1;
                  mem_addr_reg <= step(mem_addr_reg);
                  case (word_idx_reg)
                     2'h0: begin
                        cur_ctrl_reg <= mem_rdata[15:0];
                        count_reg    <= mem_rdata[7:0];
                        if (!desc_ok) begin
                           mem_req_reg  <= 1'b0;
                           word_idx_reg <= 2'h0;
                           mem_addr_reg <= desc_ptr_reg;
                           poll_cnt_reg <= 8'(POLL_CYCLES);
                           if (poll_en) begin
                              state_reg <= crypto_dma_pkg::ST_POLL;
                           end else begin
                              state_reg <= crypto_dma_pkg::ST_IDLE;
                              done_reg  <= 1'b1;
                           end
                        end
                     end
                     2'h1: src_reg <= mem_rdata;
                     2'h2: dst_reg <= mem_rdata;
                     default: begin
                        next_reg <= mem_rdata;
                        if (count_reg == 8'h00) begin
                           mem_req_reg <= 1'b0;
                           state_reg   <= crypto_dma_pkg::ST_IDLE;
                           done_reg    <= 1'b1;
                        end else begin
                           state_reg    <= crypto_dma_pkg::ST_READ;
                           mem_addr_reg <= src_reg;
                        end
                     end
                  endcase
               end
            end
            crypto_dma_pkg::ST_POLL: begin
               poll_cnt_reg <= poll_cnt_reg - 8'h01;
               if (poll_cnt_reg == 8'h01) begin
                  state_reg   <= crypto_dma_pkg::ST_DESC;
                  mem_req_reg <= 1'b1;
               end
            end
            crypto_dma_pkg::ST_READ: begin
               if (mem_ack) begin
                  state_reg     <= crypto_dma_pkg::ST_WRITE;
                  mem_we_reg    <= 1'b1;
                  mem_addr_reg  <= dst_reg;
                  mem_wdata_reg <= out_word;
               end
            end
            crypto_dma_pkg::ST_WRITE: begin
               if (mem_ack) begin
                  mem_we_reg <= 1'b0;
                  src_reg    <= step(src_reg);
                  dst_reg    <= step(dst_reg);
                  count_reg  <= count_reg - 8'h01;
                  if (count_reg != 8'h01) begin
                     state_reg    <= crypto_dma_pkg::ST_READ;
                     mem_addr_reg <= step(src_reg);
                  end else if (last_desc) begin
                     state_reg   <= crypto_dma_pkg::ST_IDLE;
                     mem_req_reg <= 1'b0;
                     done_reg    <= 1'b1;
                  end else begin
                     state_reg    <= crypto_dma_pkg::ST_DESC;
                     desc_ptr_reg <= next_reg;
                     word_idx_reg <= 2'h0;
                     mem_addr_reg <= next_reg;
                  end
               end
            end
            default: begin
               state_reg   <= crypto_dma_pkg::ST_IDLE;
               mem_req_reg <= 1'b0;
            end
         endcase
      end
   end

   assign reg_rdata = rdata_reg;
   assign mem_req   = mem_req_reg;
   assign mem_we    = mem_we_reg;
   assign mem_addr  = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic [31:0] rdata_seen;
   always_ff @(posedge clk) begin
      rdata_seen <= mem_rdata;
   end
   wire [31:0] seen_swapped = {rdata_seen[7:0], rdata_seen[15:8],
                               rdata_seen[23:16], rdata_seen[31:24]};
   wire        data_taken   = !abort && mem_ack && (state_reg == crypto_dma_pkg::ST_READ);
   wire        hdr_taken    = !abort && mem_ack && (state_reg == crypto_dma_pkg::ST_DESC)
                              && (word_idx_reg == 2'h0) && !desc_ok;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_srst_write;
      wr_ctrl && reg_wdata[crypto_dma_pkg::SRST_BIT];
   endsequence
   sequence s_busy_then_clear;
      soft_busy ##[1:8] !soft_busy;
   endsequence
   sequence s_poll_then_refetch;
      (state_reg == crypto_dma_pkg::ST_POLL) ##[1:300]
         (mem_req_reg && state_reg == crypto_dma_pkg::ST_DESC);
   endsequence

   property p_ctrl_reserved;
      reg_rd && reg_addr == crypto_dma_pkg::CTRL_ADDR |=>
         reg_rdata[31:8] == 24'h000000 && reg_rdata[4:3] == 2'h0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("control reserved bits set");

   property p_srst_clear;
      s_srst_write |=> s_busy_then_clear;
   endproperty
   a_srst_clear: assert property (p_srst_clear) else $error("soft reset did not self clear");

   property p_srst_idle;
      soft_busy |=> state_reg == crypto_dma_pkg::ST_IDLE && !mem_req_reg;
   endproperty
   a_srst_idle: assert property (p_srst_idle) else $error("processor busy during soft reset");

   property p_dma_off;
      !dma_en |=> state_reg == crypto_dma_pkg::ST_IDLE && !mem_req_reg;
   endproperty
   a_dma_off: assert property (p_dma_off) else $error("transfer while dma disabled");

   property p_fetch_off;
      !fetch_en |=> !mem_req_reg;
   endproperty
   a_fetch_off: assert property (p_fetch_off) else $error("fetch while fetch disabled");

   property p_in_swap;
      data_taken && ctrl_reg[crypto_dma_pkg::IN_SWAP_BIT]
         && !ctrl_reg[crypto_dma_pkg::OUT_SWAP_BIT] |=> mem_wdata_reg == seen_swapped;
   endproperty
   a_in_swap: assert property (p_in_swap) else $error("input word not swapped");

   property p_out_swap;
      data_taken && !ctrl_reg[crypto_dma_pkg::IN_SWAP_BIT]
         && ctrl_reg[crypto_dma_pkg::OUT_SWAP_BIT] |=> mem_wdata_reg == seen_swapped;
   endproperty
   a_out_swap: assert property (p_out_swap) else $error("output word not swapped");

   property p_no_swap;
      data_taken && !ctrl_reg[crypto_dma_pkg::IN_SWAP_BIT]
         && !ctrl_reg[crypto_dma_pkg::OUT_SWAP_BIT] |=> mem_wdata_reg == rdata_seen;
   endproperty
   a_no_swap: assert property (p_no_swap) else $error("word changed without swap");

   property p_no_poll;
      hdr_taken && !poll_en |=> state_reg == crypto_dma_pkg::ST_IDLE;
   endproperty
   a_no_poll: assert property (p_no_poll) else $error("polled with polling disabled");

   property p_poll;
      hdr_taken && poll_en && !soft_busy |=> s_poll_then_refetch;
   endproperty
   a_poll: assert property (p_poll) else $error("invalid descriptor not re-read");

   property p_active;
      reg_rd && reg_addr == crypto_dma_pkg::STAT_ADDR |=>
         reg_rdata[crypto_dma_pkg::ACTIVE_BIT] == ($past(state_reg) != crypto_dma_pkg::ST_IDLE);
   endproperty
   a_active: assert property (p_active) else $error("active flag wrong");

   property p_ctrl_word;
      reg_rd && reg_addr == crypto_dma_pkg::STAT_ADDR |=> reg_rdata[15:0] == $past(cur_ctrl_reg);
   endproperty
   a_ctrl_word: assert property (p_ctrl_word) else $error("status control word wrong");

endmodule

// file: testbench/mem_model.sv
// behavioural system memory that answers the DMA master of the control block
// assumes one clock, a held request and a combinational one-cycle ack
`timescale 1ns/1ps
module mem_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // memory bus
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic      [31:0] mem_rdata,
   output logic             mem_ack,
   // answer delay in cycles, one at least
   input  wire logic [3:0]  wait_cyc
);
   logic [31:0] mem [0:63];
   logic [3:0]  cnt_reg;
   logic [31:0] junk_reg;
   wire  [5:0]  idx = mem_addr[7:2];

   // ack only while a request stands, so a withdrawn request is never answered
   assign mem_ack   = mem_req && (cnt_reg >= wait_cyc);
   // outside an ack the data lines carry a changing pattern, not stale data
   assign mem_rdata = mem_ack ? mem[idx] : junk_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= 4'h0;
         junk_reg <= 32'h5A5A_A5A5;
      end else begin
         junk_reg <= ~junk_reg;
         cnt_reg  <= (mem_req && !mem_ack) ? cnt_reg + 4'h1 : 4'h0;
         if (mem_ack && mem_we) begin
            mem[idx] <= mem_wdata;
         end
      end
   end
endmodule

// file: testbench/crypto_dma_ctrl_tb_top.sv
// self-checking bench for the crypto engine DMA control block
// assumes the memory model above and the design's register map constants
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module crypto_dma_ctrl_tb_top;
   logic        clk;
   logic        rst;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        mem_req;
   logic        mem_we;
   logic [31:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   logic        mem_ack;
   logic [3:0]  wait_cyc;
   logic        req_q;
   int          err_total;
   int          n_compared;
   int          n_hdr;
   int          n_wr;
   int          cyc;

   crypto_dma_ctrl #(.POLL_CYCLES(2), .RESET_CYCLES(4)) DUT (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   mem_model far_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .wait_cyc(wait_cyc));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ------------------------------------------------------------
   // bus monitor and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      req_q <= mem_req;
      if (mem_req && !req_q && mem_addr === 32'h0000_0040) n_hdr++;
      if (mem_ack && mem_we) n_wr++;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // register port tasks
   // ------------------------------------------------------------
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      // read data stand only in the cycle after the strobe; take them at its closing edge
      @(posedge clk);
      d = reg_rdata;
   endtask

   function automatic logic [31:0] bswap(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      reg_read(crypto_dma_pkg::CTRL_ADDR, d);
      `CHECK("control reset", 32'h0000_0000, d)
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'hFFFF_FF98);
      reg_read(crypto_dma_pkg::CTRL_ADDR, d);
      `CHECK("control unimplemented bits", 32'h0000_0080, d)
      reg_write(crypto_dma_pkg::STAT_ADDR, 32'hFFFF_FFFF);
      reg_read(crypto_dma_pkg::STAT_ADDR, d);
      `CHECK("status read only", 32'h0000_0000, d)
      reg_read(4'hC, d);
      `CHECK("unmapped read", 32'h0000_0000, d)
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_transfer(input int k);
      logic [31:0] d;
      logic [31:0] e;
      wait_cyc <= 4'(k + 1);
      // from k of two on, an empty last descriptor is chained behind the first
      far_mem.mem[16] = k[1] ? 32'h8000_0002 : 32'h8000_8002;
      far_mem.mem[17] = 32'h0000_0080;
      far_mem.mem[18] = 32'h0000_00A0;
      far_mem.mem[19] = k[1] ? 32'h0000_0050 : 32'h0000_0000;
      far_mem.mem[20] = 32'h8000_8000;
      far_mem.mem[23] = 32'h0000_0000;
      far_mem.mem[32] = 32'h1122_3344;
      far_mem.mem[33] = 32'hA1B2_C3D4;
      // stale results from the previous pass must not satisfy the checks
      far_mem.mem[40] = 32'h0000_0000;
      far_mem.mem[41] = 32'h0000_0000;
      n_wr = 0;
      // fetch enable goes low first so the processor re-arms
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h0);
      reg_write(crypto_dma_pkg::DESC_BASE_ADDR, 32'h40);
      reg_write(crypto_dma_pkg::CTRL_ADDR, {24'h0, k[1], 1'b0, k[0], 5'h05});
      for (int i = 0; i < 300 && n_wr < 1; i++) @(posedge clk);
      reg_read(crypto_dma_pkg::STAT_ADDR, d);
      `CHECK("status while busy", {16'h0001, k[1] ? 16'h0002 : 16'h8002}, d)
      for (int i = 0; i < 300 && n_wr < 2; i++) @(posedge clk);
      idle(40);
      reg_read(crypto_dma_pkg::STAT_ADDR, d);
      `CHECK("active after last", 1'b0, d[16])
      `CHECK("final control word", k[1] ? 16'h8000 : 16'h8002, d[15:0])
      `CHECK("data writes", 2, n_wr)
      e = (k[0] ^ k[1]) ? bswap(32'h1122_3344) : 32'h1122_3344;
      `CHECK("output word 0", e, far_mem.mem[40])
      e = (k[0] ^ k[1]) ? bswap(32'hA1B2_C3D4) : 32'hA1B2_C3D4;
      `CHECK("output word 1", e, far_mem.mem[41])
      $display("test transfer %0d done", k);
   endtask

   task automatic t_poll;
      logic [31:0] d;
      wait_cyc <= 4'h1;
      far_mem.mem[16] = 32'h0000_8001;
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h0);
      n_hdr = 0;
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h7);
      idle(60);
      `CHECK("header polled", 1'b1, n_hdr >= 3)
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h6);
      idle(3);
      n_hdr = 0;
      idle(30);
      `CHECK("fetch after dma off", 0, n_hdr)
      reg_read(crypto_dma_pkg::STAT_ADDR, d);
      `CHECK("active with dma off", 1'b0, d[16])
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h0);
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h1);
      idle(30);
      `CHECK("fetch with fetch off", 0, n_hdr)
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h5);
      idle(60);
      `CHECK("no poll when off", 1, n_hdr)
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h0);
      $display("test poll done");
   endtask

   task automatic t_srst;
      logic [31:0] d;
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h47);
      reg_read(crypto_dma_pkg::CTRL_ADDR, d);
      `CHECK("soft reset set", 32'h0000_0047, d)
      idle(10);
      reg_read(crypto_dma_pkg::CTRL_ADDR, d);
      `CHECK("soft reset cleared", 32'h0000_0007, d)
      reg_write(crypto_dma_pkg::CTRL_ADDR, 32'h0);
      $display("test soft reset done");
   endtask

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      rst       = 1'b1;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      wait_cyc  = 4'h1;
      req_q     = 1'b0;
      err_total = 0;
      n_compared = 0;
      n_hdr     = 0;
      n_wr      = 0;
      cyc       = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      for (int k = 0; k < 4; k++) t_transfer(k);
      t_poll();
      t_srst();
      complete_run();
   end
endmodule
